// [seq_params.svh]
`ifndef SEQ_PARAMS_SVH
`define SEQ_PARAMS_SVH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define OFS_STEP      12'h000
`define OFS_STATUS    12'h004
`define OFS_SWTRIG    12'h008
`define OFS_BTE       12'h00C
`define OFS_ADJ       12'h010
`define OFS_HOLD      12'h014
`define OFS_C0LIM     12'h018
`define OFS_C1LIM     12'h01C
`define OFS_T0LIM     12'h020
`define OFS_T1LIM     12'h024
`define OFS_SDLIM     12'h028
`define OFS_LIT0      12'h02C
`define OFS_CNT0      12'h030
`define OFS_CNT1      12'h034
`define OFS_CHSEL     12'h038
// ------------------------------------------------------------
// step word fields and opcodes
// ------------------------------------------------------------
`define OPC_CTRL      4'h0
`define OPC_ADD       4'h1
`define OPC_COPY      4'h2
`define OPT_SD_OFF    4'h2
`define OPT_SD_ON     4'h6
`define OPT_WAIT_T0   4'h8
`define OPT_WAIT_T1   4'h9
`define OPT_WAIT_SW   4'hB
`define OPT_CH_C0     4'hC
`define OPT_CH_C1     4'hD
`define OPT_CH_L0     4'hE
`define OPT_BCAST     4'hF
`define COPY_BASE     4'h8
`define TGT_LAST      3'h5
`define CHSEL_W       6
`define ZERO16        16'h0000
`define ZERO32        32'h0000_0000
`endif

// [seq_pkg.sv]
package seq_pkg;
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_WAIT_T = 2'b01,
      ST_WAIT_S = 2'b10
   } seq_state_t;
   typedef logic [15:0] word_t;
endpackage : seq_pkg

// [limit_timer.sv]
`timescale 1ns/1ps
`include "seq_params.svh"
// counts up from zero after start until it equals the limit
module limit_timer (
   input  wire logic           clk_sys,
   input  wire logic           rst_n,
   input  wire logic           start,
   input  wire seq_pkg::word_t limit,
   output logic                done
);
   import seq_pkg::*;
   word_t count_r;
   logic  run_r;
   wire   hit = run_r && (count_r == limit);

   // ------------------------------------------------------------
   // counter
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= `ZERO16;
         run_r   <= 1'b0;
         done    <= 1'b0;
      end else begin
         done <= hit;
         if (start) begin
            count_r <= `ZERO16;
            run_r   <= 1'b1;
         end else if (hit) begin
            run_r <= 1'b0;
         end else if (run_r) begin
            count_r <= count_r + 16'h0001;
         end
      end
   end
endmodule : limit_timer

// [trig_seq.sv]
`timescale 1ns/1ps
`include "seq_params.svh"
// How it works
// RULE1: control option 0010 disables step delay timer, 0110 enables it.
// RULE2: control option 1000 starts timer 0, stalls until it equals its limit.
// RULE3: control option 1001 starts timer 1, stalls until it equals its limit.
// RULE4: control option 1011 waits for software trigger bit rising edge.
// RULE5: control option 1100 copies counter 0 into channel select.
// RULE6: control option 1101 copies counter 1 into channel select.
// RULE7: control option 1110 copies literal 0 into channel select.
// RULE8: control option 1111 pulses every trigger enabled in broadcast word.
// RULE9: add options 0000..0101 add adjust value into chosen limit or literal.
// RULE10: copy options 1000..1101 load hold value into chosen target.
// RULE11: reserved opcodes or options execute as a step with no effect.
// RULE12: step word holds opcode bits 7:4 and option bits 3:0.
module trig_seq (
   input  wire logic           clk_sys,
   input  wire logic           rst_n,
   input  wire logic           psel,
   input  wire logic           penable,
   input  wire logic           pwrite,
   input  wire logic [11:0]    paddr,
   input  wire logic [31:0]    pwdata,
   output logic [31:0]         prdata,
   output logic                pready,
   output logic                pslverr,
   output seq_pkg::word_t      trig_out,
   output logic [5:0]          conversion_channel_select,
   output logic                step_delay_timer_en,
   output logic                busy
);
   import seq_pkg::*;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   word_t      broadcast_trigger_enable_r;
   word_t      adjust_value_reg_r;
   word_t      hold_value_reg_r;
   word_t      counter0_limit_r;
   word_t      counter1_limit_r;
   word_t      timer0_limit_r;
   word_t      timer1_limit_r;
   word_t      step_delay_limit_r;
   word_t      literal0_reg_r;
   word_t      counter0_r;
   word_t      counter1_r;
   logic       software_trigger_bit_r;
   logic       swt_prev_r;
   logic [7:0] step_r;
   logic       step_go_r;
   logic       retired_r;
   seq_state_t state_r;
   seq_state_t state_nxt;
   logic       t0_done;
   logic       t1_done;
   logic       wait_t1_r;

   // ------------------------------------------------------------
   // apb decode; every access completes in its first access cycle
   // ------------------------------------------------------------
   wire        acc      = psel && penable;
   wire        wr       = acc && pwrite;
   wire [11:0] a        = paddr;
   wire        mapped   = (a <= `OFS_CHSEL) && (a[1:0] == 2'b00);
   wire        wr_step  = wr && (a == `OFS_STEP) && (state_r == ST_IDLE);
   wire        wr_sw    = wr && (a == `OFS_SWTRIG);

   // ------------------------------------------------------------
   // step decode
   // ------------------------------------------------------------
   wire [3:0] opc      = step_r[7:4];                               // RULE12
   wire [3:0] opt      = step_r[3:0];                               // RULE12
   wire       is_ctrl  = step_go_r && (opc == `OPC_CTRL);
   wire       is_add   = step_go_r && (opc == `OPC_ADD)
                         && !opt[3] && (opt[2:0] <= `TGT_LAST);     // RULE9
   wire       is_copy  = step_go_r && (opc == `OPC_COPY)
                         && opt[3] && (opt[2:0] <= `TGT_LAST);      // RULE10
   wire       do_t0    = is_ctrl && (opt == `OPT_WAIT_T0);          // RULE2
   wire       do_t1    = is_ctrl && (opt == `OPT_WAIT_T1);          // RULE3
   wire       do_sw    = is_ctrl && (opt == `OPT_WAIT_SW);          // RULE4
   wire       sw_rise  = software_trigger_bit_r && !swt_prev_r;     // RULE4
   wire [2:0] tgt      = opt[2:0];
   wire       upd      = is_add || is_copy;

   // target update value: sum for add, hold for copy
   function automatic word_t new_val(input word_t cur, input logic add);
      new_val = add ? word_t'(cur + adjust_value_reg_r) : hold_value_reg_r;
   endfunction : new_val

   // ------------------------------------------------------------
   // timers for the wait options
   // ------------------------------------------------------------
   limit_timer u_t0 (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .start   (do_t0),
      .limit   (timer0_limit_r),
      .done    (t0_done)
   );
   limit_timer u_t1 (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .start   (do_t1),
      .limit   (timer1_limit_r),
      .done    (t1_done)
   );

   // ------------------------------------------------------------
   // state machine: stall while a wait option is pending
   // ------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (do_t0 || do_t1)
               state_nxt = ST_WAIT_T;                               // RULE2
            else if (do_sw)
               state_nxt = ST_WAIT_S;                               // RULE4
         end
         ST_WAIT_T: begin
            if (wait_t1_r ? t1_done : t0_done)
               state_nxt = ST_IDLE;                                 // RULE3
         end
         ST_WAIT_S: begin
            if (sw_rise)
               state_nxt = ST_IDLE;                                 // RULE4
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r   <= ST_IDLE;
         wait_t1_r <= 1'b0;
         busy      <= 1'b0;
      end else begin
         state_r <= state_nxt;
         busy    <= wr_step || (state_nxt != ST_IDLE);
         if (do_t0 || do_t1)
            wait_t1_r <= do_t1;
      end
   end

   // ------------------------------------------------------------
   // step issue and software trigger edge
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         step_r                 <= 8'h00;
         step_go_r              <= 1'b0;
         retired_r              <= 1'b0;
         software_trigger_bit_r <= 1'b0;
         swt_prev_r             <= 1'b0;
      end else begin
         step_go_r  <= wr_step;
         swt_prev_r <= software_trigger_bit_r;
         if (wr_step)
            step_r <= pwdata[7:0];
         if (wr_sw)
            software_trigger_bit_r <= pwdata[0];
         // any step, reserved ones included, counts as executed
         if (step_go_r)
            retired_r <= 1'b1;                                      // RULE11
         else if (wr_step)
            retired_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // control actions: step delay, channel select, broadcast
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         step_delay_timer_en       <= 1'b0;
         conversion_channel_select <= 6'h00;
         trig_out                  <= `ZERO16;
      end else begin
         trig_out <= `ZERO16;
         if (is_ctrl) begin
            case (opt)
               `OPT_SD_OFF: step_delay_timer_en <= 1'b0;            // RULE1
               `OPT_SD_ON:  step_delay_timer_en <= 1'b1;            // RULE1
               `OPT_CH_C0:  conversion_channel_select
                               <= counter0_r[`CHSEL_W-1:0];         // RULE5
               `OPT_CH_C1:  conversion_channel_select
                               <= counter1_r[`CHSEL_W-1:0];         // RULE6
               `OPT_CH_L0:  conversion_channel_select
                               <= literal0_reg_r[`CHSEL_W-1:0];     // RULE7
               `OPT_BCAST:  trig_out
                               <= broadcast_trigger_enable_r;       // RULE8
               default: ;                                           // RULE11
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // limit and literal registers: software write or add/copy step
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         broadcast_trigger_enable_r <= `ZERO16;
         adjust_value_reg_r         <= `ZERO16;
         hold_value_reg_r           <= `ZERO16;
         counter0_limit_r           <= `ZERO16;
         counter1_limit_r           <= `ZERO16;
         timer0_limit_r             <= `ZERO16;
         timer1_limit_r             <= `ZERO16;
         step_delay_limit_r         <= `ZERO16;
         literal0_reg_r             <= `ZERO16;
         counter0_r                 <= `ZERO16;
         counter1_r                 <= `ZERO16;
      end else begin
         if (wr) begin
            case (a)
               `OFS_BTE:   broadcast_trigger_enable_r <= pwdata[15:0];
               `OFS_ADJ:   adjust_value_reg_r         <= pwdata[15:0];
               `OFS_HOLD:  hold_value_reg_r           <= pwdata[15:0];
               `OFS_C0LIM: counter0_limit_r           <= pwdata[15:0];
               `OFS_C1LIM: counter1_limit_r           <= pwdata[15:0];
               `OFS_T0LIM: timer0_limit_r             <= pwdata[15:0];
               `OFS_T1LIM: timer1_limit_r             <= pwdata[15:0];
               `OFS_SDLIM: step_delay_limit_r         <= pwdata[15:0];
               `OFS_LIT0:  literal0_reg_r             <= pwdata[15:0];
               `OFS_CNT0:  counter0_r                 <= pwdata[15:0];
               `OFS_CNT1:  counter1_r                 <= pwdata[15:0];
               default: ;
            endcase
         end
         // step update is after the bus write so a step wins a clash
         if (upd) begin
            case (tgt)
               3'h0: counter0_limit_r   <=
                        new_val(counter0_limit_r, is_add);          // RULE9
               3'h1: counter1_limit_r   <=
                        new_val(counter1_limit_r, is_add);          // RULE10
               3'h2: timer0_limit_r     <=
                        new_val(timer0_limit_r, is_add);
               3'h3: timer1_limit_r     <=
                        new_val(timer1_limit_r, is_add);
               3'h4: step_delay_limit_r <=
                        new_val(step_delay_limit_r, is_add);
               3'h5: literal0_reg_r     <=
                        new_val(literal0_reg_r, is_add);
               default: ;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   word_t rd_mux;
   always_comb begin
      rd_mux = `ZERO16;
      case (a)
         `OFS_STEP:   rd_mux = {8'h00, step_r};
         `OFS_STATUS: rd_mux = {12'h000, retired_r, step_delay_timer_en,
                                state_r};
         `OFS_SWTRIG: rd_mux = {15'h0000, software_trigger_bit_r};
         `OFS_BTE:    rd_mux = broadcast_trigger_enable_r;
         `OFS_ADJ:    rd_mux = adjust_value_reg_r;
         `OFS_HOLD:   rd_mux = hold_value_reg_r;
         `OFS_C0LIM:  rd_mux = counter0_limit_r;
         `OFS_C1LIM:  rd_mux = counter1_limit_r;
         `OFS_T0LIM:  rd_mux = timer0_limit_r;
         `OFS_T1LIM:  rd_mux = timer1_limit_r;
         `OFS_SDLIM:  rd_mux = step_delay_limit_r;
         `OFS_LIT0:   rd_mux = literal0_reg_r;
         `OFS_CNT0:   rd_mux = counter0_r;
         `OFS_CNT1:   rd_mux = counter1_r;
         `OFS_CHSEL:  rd_mux = {10'h000, conversion_channel_select};
         default:     rd_mux = `ZERO16;
      endcase
   end

   // registered apb answer: pready rises in the first access cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= `ZERO32;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         prdata  <= {16'h0000, rd_mux};
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   // each action lands on the edge after its decode, so expected values
   // are the operands as they stood one cycle earlier
   a_sd_disable: assert property (                              // RULE1
      @(posedge clk_sys) disable iff (!rst_n)
      is_ctrl && opt == `OPT_SD_OFF |=> !step_delay_timer_en)
      else $error("step delay not disabled");
   a_sd_enable: assert property (                               // RULE1
      @(posedge clk_sys) disable iff (!rst_n)
      is_ctrl && opt == `OPT_SD_ON |=> step_delay_timer_en)
      else $error("step delay not enabled");
   a_t0_stall: assert property (                                // RULE2
      @(posedge clk_sys) disable iff (!rst_n)
      do_t0 |=> state_r == ST_WAIT_T && !wait_t1_r)
      else $error("timer0 wait not entered");
   a_t0_hold: assert property (                                 // RULE2
      @(posedge clk_sys) disable iff (!rst_n)
      state_r == ST_WAIT_T && !wait_t1_r && !t0_done
         |=> state_r == ST_WAIT_T)
      else $error("left timer0 wait early");
   a_t0_release: assert property (                              // RULE2
      @(posedge clk_sys) disable iff (!rst_n)
      state_r == ST_WAIT_T && !wait_t1_r && t0_done |=> state_r == ST_IDLE)
      else $error("timer0 wait not ended");
   a_t1_stall: assert property (                                // RULE3
      @(posedge clk_sys) disable iff (!rst_n)
      do_t1 |=> state_r == ST_WAIT_T && wait_t1_r)
      else $error("timer1 wait not entered");
   a_sw_hold: assert property (                                 // RULE4
      @(posedge clk_sys) disable iff (!rst_n)
      state_r == ST_WAIT_S && !sw_rise |=> state_r == ST_WAIT_S)
      else $error("left sw wait without edge");
   a_chsel_c0: assert property (                                // RULE5
      @(posedge clk_sys) disable iff (!rst_n)
      is_ctrl && opt == `OPT_CH_C0 |=>
         conversion_channel_select == $past(counter0_r[5:0]))
      else $error("counter0 not copied");
   a_chsel_c1: assert property (                                // RULE6
      @(posedge clk_sys) disable iff (!rst_n)
      is_ctrl && opt == `OPT_CH_C1 |=>
         conversion_channel_select == $past(counter1_r[5:0]))
      else $error("counter1 not copied");
   a_chsel_l0: assert property (                                // RULE7
      @(posedge clk_sys) disable iff (!rst_n)
      is_ctrl && opt == `OPT_CH_L0 |=>
         conversion_channel_select == $past(literal0_reg_r[5:0]))
      else $error("literal0 not copied");
   a_bcast_out: assert property (                               // RULE8
      @(posedge clk_sys) disable iff (!rst_n)
      is_ctrl && opt == `OPT_BCAST |=>
         trig_out == $past(broadcast_trigger_enable_r)
         ##1 trig_out == `ZERO16)
      else $error("broadcast trigger wrong");
   a_add_adj: assert property (                                 // RULE9
      @(posedge clk_sys) disable iff (!rst_n)
      is_add && tgt == 3'h5 |=> literal0_reg_r ==
         16'($past(literal0_reg_r) + $past(adjust_value_reg_r)))
      else $error("add to literal0");
   a_copy_hold: assert property (                               // RULE10
      @(posedge clk_sys) disable iff (!rst_n)
      is_copy && tgt == 3'h0 |=> counter0_limit_r == $past(hold_value_reg_r))
      else $error("copy to counter0 limit");
   a_nop_quiet: assert property (                               // RULE11
      @(posedge clk_sys) disable iff (!rst_n)
      step_go_r && opc > `OPC_COPY |=> trig_out == `ZERO16
         && $stable(conversion_channel_select)
         && $stable(step_delay_timer_en) && state_r == ST_IDLE)
      else $error("reserved opcode had an effect");
endmodule : trig_seq

// [trig_sink.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// trigger and channel select receiver
// ------------------------------------------------------------
module trig_sink (
   input  wire logic           clk_sys,
   input  wire logic           rst_n,
   input  wire seq_pkg::word_t trig_out,
   input  wire logic [5:0]     conversion_channel_select,
   output seq_pkg::word_t      last_trig,
   output logic [5:0]          chan_seen,
   output int                  n_pulse
);
   import seq_pkg::*;
   // counts every cycle a trigger is high, so a stretched pulse shows up
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         last_trig <= '0;
         chan_seen <= '0;
         n_pulse   <= 0;
      end else begin
         chan_seen <= conversion_channel_select;
         if (trig_out != '0) begin
            last_trig <= trig_out;
            n_pulse   <= n_pulse + 1;
         end
      end
   end
endmodule : trig_sink

// [tb_trig_seq.sv]
`timescale 1ns/1ps
`include "seq_params.svh"
module tb_trig_seq;
   import seq_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rst_n   = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = '0;
   logic [31:0] pwdata  = '0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   word_t       trig_out;
   logic [5:0]  chsel;
   logic        sd_en;
   logic        busy;
   word_t       last_trig;
   logic [5:0]  chan_seen;
   int          n_pulse;
   logic [31:0] rdv;
   logic        rerr;
   int          err_count = 0;
   int          n_compared = 0;

   always #50 clk_sys = ~clk_sys;

   trig_seq dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .trig_out(trig_out), .conversion_channel_select(chsel),
      .step_delay_timer_en(sd_en), .busy(busy));
   trig_sink sink (.clk_sys(clk_sys), .rst_n(rst_n), .trig_out(trig_out),
      .conversion_channel_select(chsel), .last_trig(last_trig),
      .chan_seen(chan_seen), .n_pulse(n_pulse));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", s, e, g);
         err_count++;
      end
   endtask : chk

   // one apb transfer; request held until pready is sampled high
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_sys);
         if (pready === 1'b1) break;
      end
      chk("pready", 32'h1, pready);
      rdv  = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : bus

   task wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task rd(input logic [11:0] a);
      bus(1'b0, a, 32'h0000_0000);
   endtask : rd

   // issue a step and wait, bounded, until it retires; the sink registers
   // one edge behind the design, so results are read a falling edge later
   task step(input logic [7:0] c);
      int n;
      wr(`OFS_STEP, {24'h00_0000, c});
      @(negedge clk_sys);
      for (n = 0; n < 400 && busy !== 1'b0; n++) @(negedge clk_sys);
      @(negedge clk_sys);
      chk("step retired", 32'h0, busy);
   endtask : step

   task stop_test;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : stop_test

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task t_reset;
      chk("chsel", 32'h0, chsel);
      chk("sd_en", 32'h0, sd_en);
      chk("busy", 32'h0, busy);
      rd(`OFS_STATUS);
      chk("status", 32'h0, rdv);
      chk("status err", 32'h0, rerr);
      rd(12'h03C);
      chk("unmapped err", 32'h1, rerr);
      chk("unmapped data", 32'h0, rdv);
      rd(12'h006);
      chk("unaligned err", 32'h1, rerr);
      $display("test reset done");
   endtask : t_reset

   task t_delay;
      step(8'h06);
      chk("sd on", 32'h1, sd_en);
      rd(`OFS_STATUS);
      chk("status sd", 32'h1, rdv[2]);
      chk("status retired", 32'h1, rdv[3]);
      step(8'h02);
      chk("sd off", 32'h0, sd_en);
      $display("test step delay done");
   endtask : t_delay

   // add then copy into each of the six targets
   task t_addcopy;
      logic [11:0] a;
      for (int i = 0; i < 6; i++) begin
         a = `OFS_C0LIM + 12'(4 * i);
         wr(`OFS_ADJ, 32'h3 + i);
         wr(a, 32'h0100 + i);
         step({4'h1, 4'(i)});
         rd(a);
         chk("add target", 32'h0103 + 2 * i, rdv);
         wr(`OFS_HOLD, 32'h0040 + i);
         step({4'h2, 4'h8 + 4'(i)});
         rd(a);
         chk("copy target", 32'h0040 + i, rdv);
      end
      $display("test add copy done");
   endtask : t_addcopy

   task t_chan;
      wr(`OFS_CNT0, 32'h2A);
      step(8'h0C);
      chk("chsel c0", 32'h2A, chan_seen);
      wr(`OFS_CNT1, 32'h7F);
      step(8'h0D);
      chk("chsel c1", 32'h3F, chan_seen);
      step(8'h0E);
      chk("chsel l0", 32'h05, chan_seen);
      rd(`OFS_CHSEL);
      chk("chsel reg", 32'h05, rdv);
      $display("test channel select done");
   endtask : t_chan

   task t_bcast;
      int p;
      wr(`OFS_BTE, 32'hA5C3);
      p = n_pulse;
      step(8'h0F);
      chk("trig word", 32'hA5C3, last_trig);
      chk("pulse count", p + 1, n_pulse);
      $display("test broadcast done");
   endtask : t_bcast

   // busy span must follow the selected timer's limit
   task t_timer(input logic [3:0] opt, input logic [11:0] la, input int lim);
      int n;
      wr(la, lim);
      wr(`OFS_STEP, {28'h000_0000, opt});
      repeat (2) @(posedge clk_sys);
      for (n = 0; n < 400 && busy !== 1'b0; n++) @(posedge clk_sys);
      chk("wait span", 32'h1, n >= lim - 2 && n <= lim + 6);
      $display("test timer %h done", opt);
   endtask : t_timer

   // a trigger bit already high must not end the wait
   task t_swtrig;
      step(8'h0F);
      wr(`OFS_SWTRIG, 32'h1);
      wr(`OFS_STEP, 32'h0B);
      repeat (10) @(posedge clk_sys);
      chk("held high", 32'h1, busy);
      rd(`OFS_STATUS);
      chk("sw state", 32'h2, rdv[1:0]);
      wr(`OFS_STEP, 32'h06);
      wr(`OFS_SWTRIG, 32'h0);
      repeat (6) @(posedge clk_sys);
      chk("held low", 32'h1, busy);
      wr(`OFS_SWTRIG, 32'h1);
      repeat (4) @(posedge clk_sys);
      chk("released", 32'h0, busy);
      chk("refused step", 32'h0, sd_en);
      $display("test software trigger done");
   endtask : t_swtrig

   // reserved commands and options leave every state alone
   task t_reserved;
      logic [7:0] codes [14];
      logic [31:0] lims [6];
      int p;
      codes = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h07, 8'h0A, 8'h16,
                8'h17, 8'h20, 8'h27, 8'h2E, 8'h2F, 8'h3F};
      for (int i = 0; i < 6; i++) begin
         rd(`OFS_C0LIM + 12'(4 * i));
         lims[i] = rdv;
      end
      p = n_pulse;
      foreach (codes[k]) step(codes[k]);
      step(8'hF8);
      for (int i = 0; i < 6; i++) begin
         rd(`OFS_C0LIM + 12'(4 * i));
         chk("nop limit", lims[i], rdv);
      end
      chk("nop chsel", 32'h05, chsel);
      chk("nop sd", 32'h0, sd_en);
      chk("nop pulse", p, n_pulse);
      chk("nop busy", 32'h0, busy);
      $display("test reserved done");
   endtask : t_reserved

   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      t_reset;
      t_delay;
      t_addcopy;
      t_chan;
      t_bcast;
      t_timer(4'h8, `OFS_T0LIM, 20);
      t_timer(4'h9, `OFS_T1LIM, 35);
      t_swtrig;
      t_reserved;
      stop_test;
   end

   // whole run needs about 500 cycles; a hang is cut well above that
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_count++;
      stop_test;
   end
endmodule : tb_trig_seq
